// [common/mpd_consts.vh]
// Constants for the packet DMA and its packet number queues.
// Included by the design, checker and bench files; holds definitions only.
`ifndef MPD_CONSTS_VH
`define MPD_CONSTS_VH
// APB register byte offsets
`define MPD_A_CTRL     12'h000
`define MPD_A_PNUM     12'h004
`define MPD_A_CMD      12'h008
`define MPD_A_PORTS    12'h00C
`define MPD_A_STAT     12'h010
`define MPD_A_FILT     12'h014
`define MPD_A_CNT      12'h018
`define MPD_A_ADDR     12'h01C
// Control register bits
`define MPD_C_TXEN     0
`define MPD_C_RECEIVE_ENABLE_BIT     1
`define MPD_C_BADCRC   2
`define MPD_C_AUTOREL  3
`define MPD_C_MONCS    4
`define MPD_C_STPHB    5
`define MPD_C_ACCEPT_ALL_MULTICAST    6
`define MPD_C_PROMISCUOUS_BIT     7
`define MPD_C_STCRC    8
// Command codes
`define MPD_CMD_ENQ    4'h1
`define MPD_CMD_TXACK  4'h2
`define MPD_CMD_RXREM  4'h3
`define MPD_CMD_RXREL  4'h4
// Status register bits
`define MPD_S_TXEMPTY  0
`define MPD_S_TXINT    1
`define MPD_S_RXOVRN   2
`define MPD_S_RXABORT  3
`define MPD_S_CNTMAX   4
`define MPD_S_RXEMPTY  5
// Queue geometry and limits
`define MPD_QDEPTH     18
`define MPD_QPTRW      5
`define MPD_PNW        5
`define MPD_AW         11
`define MPD_RETRY_MAX  5'h10
`define MPD_RX_MAXLEN  11'h5FC
`define MPD_HDR_WORDS  11'h004
`define MPD_CNT_MAX    4'hF
`define MPD_UNMAPPED   32'hDEAD_0000
`endif

// [design/mpd_dma.v]
// Packet DMA between a CSMA/CD MAC and the packet memory arbiter / MMU,
// with the transmit, completion and receive packet number queues.
// Assumes one clock, an APB master for software, and a MAC / arbiter
// on the same clock whose pulses are one cycle wide.
//
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/10ps
`include "mpd_consts.vh"
module mpd_dma (
   input  wire        clk_sys,
   input  wire        rst_n,
   input  wire [11:0] paddr,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        mac_tx_ready,     // MAC can take the next frame
   input  wire        mac_tx_ok,        // Pulse: frame sent
   input  wire        mac_tx_coll,      // Pulse: collision
   input  wire        mac_tx_late,      // Pulse: late collision
   input  wire        mac_tx_lostcrs,   // Pulse: carrier lost
   input  wire        mac_tx_hb_err,    // Pulse: heartbeat error
   input  wire        mac_rx_active,    // Pulse: reception started
   input  wire        mac_rx_fifo_ne,   // MAC receive FIFO holds data
   input  wire [1:0]  mac_rx_dst_kind,  // 0 own,1 broadcast,2 multicast,3 other
   input  wire        mac_rx_mc_hit,    // Multicast table match
   input  wire        mac_rx_dst_valid, // Pulse: destination known
   input  wire        mac_rx_done,      // Pulse: frame ended
   input  wire        mac_rx_crc_ok,    // CRC good with done
   input  wire [15:0] mac_rx_status,    // Receive status word
   input  wire        mac_rx_is_crc,    // Current byte is CRC
   input  wire        mmu_alloc_ok,     // Pulse: allocation granted
   input  wire        mmu_alloc_fail,   // Pulse: allocation refused
   input  wire [4:0]  mmu_alloc_pn,     // Granted packet number
   input  wire        arb_ack,          // Memory cycle done
   output reg         mmu_alloc_req,    // Allocation request level
   output reg         mmu_rel_req,      // Pulse: release
   output reg  [4:0]  mmu_rel_pn,       // Number to release
   output reg         arb_tx_req,       // Transmit read request
   output reg         arb_rx_req,       // Receive write request
   output reg  [4:0]  arb_pn,           // Packet number of cycle
   output reg  [10:0] tx_addr,          // Transmit address counter
   output reg  [10:0] rx_addr,          // Receive address counter
   output reg         mac_tx_start,     // Pulse: start frame
   output reg         mac_rx_flush,     // Pulse: flush MAC FIFO
   output reg         mac_rx_stop,      // Pulse: stop reception
   output reg         rx_overrun_irq    // Latched overrun level
);
   // Receive machine states
   localparam RX_IDLE = 3'h0;
   localparam RX_ALOC = 3'h1;
   localparam RX_DATA = 3'h2;
   localparam RX_HOLD = 3'h3;
   localparam RX_FAIL = 3'h4;

   reg [8:0]  ctrl_reg;       // Control bits, software and MAC
   reg [4:0]  pnum_reg;       // Packet number for enqueue
   reg [5:0]  stat_reg;       // Status bits; bits 2 to 4 sticky, the rest follow the queues
   reg [3:0]  coll_cnt_reg;   // Single collision counter
   reg [3:0]  late_cnt_reg;   // Late collision counter
   reg [4:0]  retry_reg;      // Collisions of this frame
   reg        tx_busy_reg;    // A frame is in flight
   reg [2:0]  rx_st_reg;      // Receive state
   reg [4:0]  rx_pn_reg;      // Number from last allocation
   reg [10:0] rx_len_reg;     // Received byte count

   // Three queues as arrays with circular pointers; never full by design
   reg [4:0] q_mem [0:2][0:`MPD_QDEPTH-1];
   reg [4:0] q_rd  [0:2];
   reg [4:0] q_wr  [0:2];
   reg [4:0] q_cnt [0:2];
   reg [2:0] q_push;
   reg [2:0] q_pop;
   reg [4:0] q_din [0:2];
   wire [2:0] q_ne;

   wire bus_wr   = psel & penable & pwrite;
   wire bus_rd   = psel & ~penable & ~pwrite;
   wire cmd_hit  = bus_wr & (paddr == `MPD_A_CMD);
   wire [3:0] cmd = pwdata[3:0];
   wire tx_err   = (retry_reg == `MPD_RETRY_MAX - 5'h01 && mac_tx_coll) | mac_tx_late
                 | (mac_tx_lostcrs & ctrl_reg[`MPD_C_MONCS])
                 | (mac_tx_hb_err & ctrl_reg[`MPD_C_STPHB]);
   // Destination acceptance
   wire dst_ok = ctrl_reg[`MPD_C_PROMISCUOUS_BIT] | (mac_rx_dst_kind == 2'h0)
               | (mac_rx_dst_kind == 2'h1)
               | ((mac_rx_dst_kind == 2'h2)
                  & (ctrl_reg[`MPD_C_ACCEPT_ALL_MULTICAST] | mac_rx_mc_hit));

   // Per-queue storage, one instance of logic per queue
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : gq
         assign q_ne[g] = (q_cnt[g] != 5'h00);
         always @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
               q_rd[g]  <= 5'h00;
               q_wr[g]  <= 5'h00;
               q_cnt[g] <= 5'h00;
            end else begin
               // Push writes tail; wrap at depth
               if (q_push[g]) begin
                  q_mem[g][q_wr[g]] <= q_din[g];
                  q_wr[g] <= (q_wr[g] == `MPD_QDEPTH - 1) ? 5'h00 : q_wr[g] + 5'h01;
               end
               // Pop only when something is there
               if (q_pop[g] && q_ne[g])
                  q_rd[g] <= (q_rd[g] == `MPD_QDEPTH - 1) ? 5'h00 : q_rd[g] + 5'h01;
               q_cnt[g] <= q_cnt[g] + {4'h0, q_push[g]} - {4'h0, q_pop[g] & q_ne[g]};
            end
         end
      end
   endgenerate

   // Queue steering: 0 transmit, 1 completion, 2 receive
   always @* begin
      q_push   = 3'h0;
      q_pop    = 3'h0;
      q_din[0] = pnum_reg;
      q_din[1] = q_mem[0][q_rd[0]];
      q_din[2] = rx_pn_reg;
      if (cmd_hit && cmd == `MPD_CMD_ENQ)
         q_push[0] = 1'b1;
      if (cmd_hit && cmd == `MPD_CMD_TXACK)
         q_pop[1] = 1'b1;
      if (cmd_hit && (cmd == `MPD_CMD_RXREM || cmd == `MPD_CMD_RXREL))
         q_pop[2] = 1'b1;
      if (tx_busy_reg && mac_tx_ok) begin
         q_pop[0] = 1'b1;
         q_push[1] = ~ctrl_reg[`MPD_C_AUTOREL];
      end else if (tx_busy_reg && tx_err) begin
         q_pop[0] = 1'b1;
         q_push[1] = 1'b1;
      end
      if (rx_st_reg == RX_DATA && mac_rx_done && !mac_rx_fifo_ne
          && (mac_rx_crc_ok || ctrl_reg[`MPD_C_BADCRC]))
         q_push[2] = 1'b1;
   end

   // Transmit side and control register
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_reg     <= 9'h000;
         pnum_reg     <= 5'h00;
         tx_busy_reg  <= 1'b0;
         retry_reg    <= 5'h00;
         tx_addr      <= 11'h000;
         arb_tx_req   <= 1'b0;
         mac_tx_start <= 1'b0;
         coll_cnt_reg <= 4'h0;
         late_cnt_reg <= 4'h0;
      end else begin
         mac_tx_start <= 1'b0;
         if (bus_wr && paddr == `MPD_A_CTRL)
            ctrl_reg <= pwdata[8:0];
         if (bus_wr && paddr == `MPD_A_PNUM)
            pnum_reg <= pwdata[4:0];
         // Start only when enabled and an entry waits
         if (!tx_busy_reg && ctrl_reg[`MPD_C_TXEN] && q_ne[0] && mac_tx_ready) begin
            tx_busy_reg  <= 1'b1;
            mac_tx_start <= 1'b1;
            tx_addr      <= 11'h000;
            retry_reg    <= 5'h00;
         end
         // Word reads follow arbiter acknowledges
         arb_tx_req <= tx_busy_reg;
         if (tx_busy_reg && arb_ack && arb_tx_req)
            tx_addr <= tx_addr + 11'h002;
         if (tx_busy_reg && mac_tx_ok) begin
            tx_busy_reg <= 1'b0;
         end else if (tx_busy_reg && tx_err) begin
            tx_busy_reg <= 1'b0;
            ctrl_reg[`MPD_C_TXEN] <= 1'b0;
         end else if (tx_busy_reg && mac_tx_coll) begin
            retry_reg    <= retry_reg + 5'h01;
            tx_addr      <= 11'h000;
            mac_tx_start <= 1'b1;
         end
         // Counters step once per collision pulse and stick at maximum
         if (mac_tx_coll && coll_cnt_reg != `MPD_CNT_MAX)
            coll_cnt_reg <= coll_cnt_reg + 4'h1;
         if (mac_tx_late && late_cnt_reg != `MPD_CNT_MAX)
            late_cnt_reg <= late_cnt_reg + 4'h1;
      end
   end

   // Receive machine
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rx_st_reg     <= RX_IDLE;
         rx_pn_reg     <= 5'h00;
         rx_len_reg    <= 11'h000;
         rx_addr       <= 11'h000;
         mmu_alloc_req <= 1'b0;
         mmu_rel_req   <= 1'b0;
         mmu_rel_pn    <= 5'h00;
         arb_rx_req    <= 1'b0;
         mac_rx_stop   <= 1'b0;
         mac_rx_flush  <= 1'b0;
      end else begin
         mmu_rel_req  <= 1'b0;
         mac_rx_stop  <= 1'b0;
         mac_rx_flush <= 1'b0;
         // Software release of receive head, or auto release after send
         if (cmd_hit && cmd == `MPD_CMD_RXREL && q_ne[2]) begin
            mmu_rel_req <= 1'b1;
            mmu_rel_pn  <= q_mem[2][q_rd[2]];
         end else if (tx_busy_reg && mac_tx_ok && ctrl_reg[`MPD_C_AUTOREL]) begin
            mmu_rel_req <= 1'b1;
            mmu_rel_pn  <= q_mem[0][q_rd[0]];
         end
         case (rx_st_reg)
            RX_IDLE: begin
               if (mac_rx_active && ctrl_reg[`MPD_C_RECEIVE_ENABLE_BIT]) begin
                  mmu_alloc_req <= 1'b1;
                  rx_st_reg     <= RX_ALOC;
               end
            end
            RX_ALOC: begin
               if (mmu_alloc_ok) begin
                  mmu_alloc_req <= 1'b0;
                  rx_pn_reg     <= mmu_alloc_pn;
                  rx_addr       <= `MPD_HDR_WORDS;
                  rx_len_reg    <= 11'h000;
                  rx_st_reg     <= RX_DATA;
               end else if (mmu_alloc_fail) begin
                  mmu_alloc_req <= 1'b0;
                  rx_st_reg     <= RX_FAIL;
               end
            end
            RX_DATA: begin
               arb_rx_req <= mac_rx_fifo_ne;
               if (arb_rx_req && arb_ack) begin
                  rx_addr    <= rx_addr + 11'h002;
                  rx_len_reg <= rx_len_reg + 11'h002;
               end
               if ((mac_rx_dst_valid && !dst_ok) || rx_len_reg > `MPD_RX_MAXLEN) begin
                  mmu_rel_req <= 1'b1;
                  mmu_rel_pn  <= rx_pn_reg;
                  mac_rx_stop <= 1'b1;
                  arb_rx_req  <= 1'b0;
                  rx_st_reg   <= RX_IDLE;
               end else if (mac_rx_done && !mac_rx_fifo_ne) begin
                  // Address back to header slot; RX_HOLD then returns to idle
                  rx_addr    <= 11'h000;
                  arb_rx_req <= 1'b0;
                  rx_st_reg  <= RX_HOLD;
                  if (!(mac_rx_crc_ok || ctrl_reg[`MPD_C_BADCRC])) begin
                     mmu_rel_req <= 1'b1;
                     mmu_rel_pn  <= rx_pn_reg;
                  end
               end
            end
            RX_HOLD: rx_st_reg <= RX_IDLE;
            RX_FAIL: begin
               if (mac_rx_active) begin
                  mac_rx_flush <= 1'b1;
                  rx_st_reg    <= RX_IDLE;
               end
            end
            default: rx_st_reg <= RX_IDLE;
         endcase
      end
   end

   // Status, sticky in bits 2 to 4; a set in the same cycle beats the clear
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         stat_reg       <= 6'h00;
         rx_overrun_irq <= 1'b0;
      end else begin
         if (bus_wr && paddr == `MPD_A_STAT)
            stat_reg[4:2] <= stat_reg[4:2] & ~pwdata[4:2];
         stat_reg[`MPD_S_TXEMPTY] <= ~q_ne[0];
         stat_reg[`MPD_S_TXINT]   <= q_ne[1];
         stat_reg[`MPD_S_RXEMPTY] <= ~q_ne[2];
         if (rx_st_reg == RX_FAIL && mac_rx_fifo_ne)
            stat_reg[`MPD_S_RXOVRN] <= 1'b1;
         if (rx_st_reg == RX_DATA && rx_len_reg > `MPD_RX_MAXLEN)
            stat_reg[`MPD_S_RXABORT] <= 1'b1;
         if (coll_cnt_reg == `MPD_CNT_MAX || late_cnt_reg == `MPD_CNT_MAX)
            stat_reg[`MPD_S_CNTMAX] <= 1'b1;
         rx_overrun_irq <= stat_reg[`MPD_S_RXOVRN];
      end
   end

   // APB slave: zero wait states, read data set in setup cycle
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
         arb_pn  <= 5'h00;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= 1'b0;
         arb_pn  <= arb_rx_req ? rx_pn_reg : q_mem[0][q_rd[0]];
         if (bus_rd) begin
            case (paddr)
               `MPD_A_CTRL:  prdata <= {23'h0, ctrl_reg};
               `MPD_A_PNUM:  prdata <= {27'h0, pnum_reg};
               `MPD_A_CMD:   prdata <= 32'h0000_0000;
               `MPD_A_PORTS: prdata <= {16'h0, ~q_ne[2], 2'h0, q_mem[2][q_rd[2]],
                                        ~q_ne[1], 2'h0, q_mem[1][q_rd[1]]};
               `MPD_A_STAT:  prdata <= {26'h0, stat_reg};
               `MPD_A_FILT:  prdata <= {16'h0, mac_rx_status};
               `MPD_A_CNT:   prdata <= {24'h0, late_cnt_reg, coll_cnt_reg};
               `MPD_A_ADDR:  prdata <= {5'h0, rx_addr, 5'h0, tx_addr};
               default: begin
                  prdata  <= `MPD_UNMAPPED;
               end
            endcase
         end
      end
   end
endmodule

// [verif/mpd_dma_assertions.sv]
// Port-level checker for the packet DMA, bound to every mpd_dma instance.
// Assumes software alone writes CTRL over APB; hardware clears only bit 0.
`timescale 1ns/10ps
`include "mpd_consts.vh"
module mpd_dma_assertions (
   input wire        clk_sys,
   input wire        rst_n,
   input wire [11:0] paddr,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [31:0] pwdata,
   input wire        pready,
   input wire        mac_tx_ok,
   input wire        mac_tx_coll,
   input wire        mac_rx_active,
   input wire        mac_rx_fifo_ne,
   input wire        mmu_alloc_ok,
   input wire        mmu_alloc_fail,
   input wire        mmu_alloc_req,
   input wire        mmu_rel_req,
   input wire [10:0] rx_addr,
   input wire        mac_tx_start,
   input wire        mac_rx_flush,
   input wire        mac_rx_stop,
   input wire        rx_overrun_irq
);
   wire       wr_w  = psel && penable && pwrite;   // Write lands at access edge
   wire       clr_w = wr_w && paddr == `MPD_A_STAT && pwdata[`MPD_S_RXOVRN];
   reg  [8:0] ctrl_reg;                            // Software view of control
   reg        fail_reg;                            // Last allocation refused
   reg  [4:0] coll_reg;                            // Collisions on this frame
   // Shadow state; hardware may clear the enable bit
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_reg <= 9'h000;
         fail_reg <= 1'b0;
         coll_reg <= 5'h00;
      end else begin
         if (wr_w && paddr == `MPD_A_CTRL)
            ctrl_reg <= pwdata[8:0];
         if (mmu_alloc_fail)
            fail_reg <= 1'b1;
         else if (mac_rx_active)
            fail_reg <= 1'b0;
         if (mac_tx_ok || (mac_tx_coll && coll_reg == 5'h0F))
            coll_reg <= 5'h00;
         else if (mac_tx_coll)
            coll_reg <= coll_reg + 5'h01;
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   a_apb_zero_wait: assert property (psel && !penable |=> pready)
      else $error("APB access not answered in next cycle");
   a_alloc_on_rx: assert property (mac_rx_active && ctrl_reg[`MPD_C_RECEIVE_ENABLE_BIT] &&
      !mmu_alloc_req && !fail_reg |=> mmu_alloc_req) else $error("No allocation request");
   a_rx_hdr_skip: assert property (mmu_alloc_req && mmu_alloc_ok
      |=> rx_addr == `MPD_HDR_WORDS) else $error("Receive address not past header");
   a_stop_frees: assert property (mac_rx_stop |->
      (mmu_rel_req || $past(mmu_rel_req)) or ##1 mmu_rel_req) else $error("Stop without free");
   a_auto_release: assert property (mac_tx_ok && ctrl_reg[`MPD_C_AUTOREL]
      |=> mmu_rel_req) else $error("No release after send");
   a_flush_next: assert property (mac_rx_active && fail_reg && ctrl_reg[`MPD_C_RECEIVE_ENABLE_BIT]
      |-> ##[1:2] mac_rx_flush) else $error("No flush after failed allocation");
   a_overrun_set: assert property (mmu_alloc_fail && mac_rx_fifo_ne
      |-> ##[1:3] rx_overrun_irq) else $error("Overrun not raised");
   a_overrun_held: assert property (rx_overrun_irq && !clr_w && !$past(clr_w)
      |=> rx_overrun_irq) else $error("Overrun dropped without clear");
   a_coll_restart: assert property (mac_tx_coll && coll_reg < 5'h0F
      |-> ##[1:2] mac_tx_start) else $error("No restart after collision");
   a_retry_stop: assert property (mac_tx_coll && coll_reg == 5'h0F
      |=> (!mac_tx_start) [*8]) else $error("Start after retry limit");
   c_grant: cover property (mmu_alloc_req && mmu_alloc_ok);
   c_flush: cover property (mac_rx_flush);
   c_retry_limit: cover property (mac_tx_coll && coll_reg == 5'h0F);
endmodule
bind mpd_dma mpd_dma_assertions mpd_dma_assertions_i (.*);

// [verif/mpd_partner.sv]
// Model of the MMU allocator and memory arbiter facing the packet DMA.
// Assumes the DMA holds its request level until answered; same clock.
`timescale 1ns/10ps
module mpd_partner (
   input  wire       clk_sys,
   input  wire       rst_n,
   input  wire       mmu_alloc_req,
   input  wire       arb_tx_req,
   input  wire       arb_rx_req,
   input  wire       refuse,          // Answer allocations with failure
   input  wire       slow,            // Delay each allocation answer
   output reg        mmu_alloc_ok,
   output reg        mmu_alloc_fail,
   output reg  [4:0] mmu_alloc_pn,
   output reg        arb_ack
);
   reg [1:0] wait_reg;                // Cycles left before answering
   reg       done_reg;                // Request already answered
   reg [4:0] next_reg;                // Next number handed out
   // One answer per request; number bus churns when not valid
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         mmu_alloc_ok <= 1'b0;
         mmu_alloc_fail <= 1'b0;
         mmu_alloc_pn <= 5'h00;
         arb_ack <= 1'b0;
         wait_reg <= 2'h0;
         done_reg <= 1'b0;
         next_reg <= 5'h03;
      end else begin
         mmu_alloc_ok <= 1'b0;
         mmu_alloc_fail <= 1'b0;
         mmu_alloc_pn <= ~mmu_alloc_pn;
         arb_ack <= (arb_tx_req | arb_rx_req) & ~arb_ack;
         if (!mmu_alloc_req) begin
            done_reg <= 1'b0;
            wait_reg <= slow ? 2'h3 : 2'h0;
         end else if (!done_reg && wait_reg != 2'h0) begin
            wait_reg <= wait_reg - 2'h1;
         end else if (!done_reg) begin
            done_reg <= 1'b1;
            mmu_alloc_fail <= refuse;
            mmu_alloc_ok <= !refuse;
            mmu_alloc_pn <= next_reg;
            next_reg <= next_reg + 5'h01;
         end
      end
   end
endmodule

// [verif/testbench.sv]
// Bench for the packet DMA: APB tasks act as software, the bench
// drives the MAC side, mpd_partner answers MMU and arbiter.
`timescale 1ns/10ps
`include "mpd_consts.vh"
module testbench;
   reg         clk_sys, rst_n, psel, penable, pwrite;
   reg  [11:0] paddr;
   reg  [31:0] pwdata, rd;
   reg         mac_tx_ready, fifo_ne, mc_hit, crc_ok, refuse, slow;
   reg  [1:0]  dst_kind;
   reg  [7:0]  ev;                 // MAC event pulses, one bit each
   reg  [4:0]  got_pn, rel_pn;
   reg  [4:0]  acc [0:5];          // Receive numbers in expected order
   wire [31:0] prdata;
   wire [4:0]  mmu_alloc_pn, mmu_rel_pn;
   wire        pready, mmu_alloc_ok, mmu_alloc_fail, mmu_alloc_req, mmu_rel_req;
   wire        arb_tx_req, arb_rx_req, arb_ack, mac_tx_start, mac_rx_flush;
   wire        mac_rx_stop, rx_overrun_irq;
   integer     mismatches, tests_run, i, j, s;
   integer     cnt [0:3];          // Starts, stops, flushes, grants
   // Filter cases: control byte, destination kind, table hit, stop expected
   localparam [71:0] FILT = {12'h024, 12'h82C, 12'h428, 12'h02A, 12'h029, 12'h02D};
   mpd_dma mpd_dma_i (
      .clk_sys(clk_sys), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(),
      .mac_tx_ready(mac_tx_ready), .mac_tx_ok(ev[0]), .mac_tx_coll(ev[1]),
      .mac_tx_late(ev[2]), .mac_tx_lostcrs(ev[3]), .mac_tx_hb_err(ev[4]),
      .mac_rx_active(ev[5]), .mac_rx_fifo_ne(fifo_ne), .mac_rx_dst_kind(dst_kind),
      .mac_rx_mc_hit(mc_hit), .mac_rx_dst_valid(ev[6]), .mac_rx_done(ev[7]),
      .mac_rx_crc_ok(crc_ok), .mac_rx_status(16'h5A5A), .mac_rx_is_crc(1'b0),
      .mmu_alloc_ok(mmu_alloc_ok), .mmu_alloc_fail(mmu_alloc_fail),
      .mmu_alloc_pn(mmu_alloc_pn), .arb_ack(arb_ack), .mmu_alloc_req(mmu_alloc_req),
      .mmu_rel_req(mmu_rel_req), .mmu_rel_pn(mmu_rel_pn), .arb_tx_req(arb_tx_req),
      .arb_rx_req(arb_rx_req), .arb_pn(), .tx_addr(), .rx_addr(),
      .mac_tx_start(mac_tx_start), .mac_rx_flush(mac_rx_flush),
      .mac_rx_stop(mac_rx_stop), .rx_overrun_irq(rx_overrun_irq));
   mpd_partner mpd_partner_i (.*);
   always #5 clk_sys = ~clk_sys;
   // Event counts and captured numbers
   always @(posedge clk_sys) begin
      if (mac_tx_start) cnt[0] <= cnt[0] + 1;
      if (mac_rx_stop) cnt[1] <= cnt[1] + 1;
      if (mac_rx_flush) cnt[2] <= cnt[2] + 1;
      if (mmu_alloc_ok) cnt[3] <= cnt[3] + 1;
      if (mmu_alloc_ok) got_pn <= mmu_alloc_pn;
      if (mmu_rel_req) rel_pn <= mmu_rel_pn;
   end
   task end_sim;
      begin
         $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
         if (mismatches == 0 && tests_run > 0) $display("Test passed");
         else $display("Test failed");
         $finish;
      end
   endtask
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         tests_run = tests_run + 1;
         if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("Error at %0t: saw %h, wanted %h", $time, seen, exp);
         end
      end
   endtask
   task hang;
      begin
         mismatches = mismatches + 1;
         $display("Error at %0t: wait ran out", $time);
         end_sim;
      end
   endtask
   // One APB transfer; request held until pready is seen at an edge
   task apb(input w, input [11:0] a, input [31:0] d);
      integer n;
      begin
         @(posedge clk_sys);
         {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
         @(posedge clk_sys);
         penable <= 1'b1;
         n = 0;
         @(posedge clk_sys);
         while (pready !== 1'b1 && n < 40) begin
            n = n + 1;
            @(posedge clk_sys);
         end
         if (n == 40) hang;
         rd = prdata;
         {psel, penable} <= 2'b00;
      end
   endtask
   task wfor(input integer k, input integer want);
      integer n;
      begin
         for (n = 0; cnt[k] < want && n < 60; n = n + 1) @(posedge clk_sys);
         if (cnt[k] < want) hang;
      end
   endtask
   task fire(input [7:0] v);
      begin
         @(posedge clk_sys);
         ev <= v;
         @(posedge clk_sys);
         ev <= 8'h00;
      end
   endtask
   task enq(input [4:0] p);
      begin
         apb(1'b1, `MPD_A_PNUM, {27'h0, p});
         apb(1'b1, `MPD_A_CMD, {28'h0, `MPD_CMD_ENQ});
      end
   endtask
   // One received frame; done is skipped when the DMA already stopped it
   task rxf(input [1:0] k, input h, input c);
      integer a;
      begin
         a = cnt[3];
         s = cnt[1];
         {fifo_ne, dst_kind, mc_hit, crc_ok} <= {1'b1, k, h, c};
         fire(8'h20);
         wfor(3, a + 1);
         fire(8'h40);
         fifo_ne <= 1'b0;
         repeat (3) @(posedge clk_sys);
         if (cnt[1] == s) fire(8'h80);
         repeat (3) @(posedge clk_sys);
      end
   endtask
   initial begin
      {clk_sys, rst_n, psel, penable, pwrite, paddr, pwdata} = 0;
      {mac_tx_ready, fifo_ne, mc_hit, crc_ok, refuse, slow, dst_kind, ev} = 0;
      {mismatches, tests_run, j} = 0;
      for (i = 0; i < 4; i = i + 1) cnt[i] = 0;
      repeat (12) @(posedge clk_sys);
      rst_n <= 1'b1;
      apb(1'b0, `MPD_A_PORTS, 32'h0);
      chk(rd & 32'h8080, 32'h8080);
      apb(1'b0, `MPD_A_STAT, 32'h0);
      chk(rd & 32'h1F, 32'h01);
      apb(1'b0, 12'h020, 32'h0);
      chk(rd, `MPD_UNMAPPED);
      // Transmit: numbers out of allocation order, held until enabled
      mac_tx_ready <= 1'b1;
      enq(5'h09);
      enq(5'h05);
      repeat (10) @(posedge clk_sys);
      chk(cnt[0], 0);
      apb(1'b1, `MPD_A_CTRL, 32'h1);
      wfor(0, 1);
      fire(8'h02);
      wfor(0, 2);
      fire(8'h01);
      wfor(0, 3);
      apb(1'b0, `MPD_A_PORTS, 32'h0);
      chk(rd & 32'h9F, 32'h09);
      apb(1'b0, `MPD_A_STAT, 32'h0);
      chk(rd & 32'h02, 32'h02);
      apb(1'b1, `MPD_A_CTRL, 32'h9);
      fire(8'h01);
      repeat (3) @(posedge clk_sys);
      chk(rel_pn, 32'h05);
      apb(1'b1, `MPD_A_CMD, {28'h0, `MPD_CMD_TXACK});
      apb(1'b0, `MPD_A_PORTS, 32'h0);
      chk(rd & 32'h80, 32'h80);
      // Sixteen collisions stop the queue until software re-enables
      apb(1'b1, `MPD_A_CTRL, 32'h1);
      enq(5'h07);
      wfor(0, 4);
      for (i = 1; i <= 16; i = i + 1) begin
         fire(8'h02);
         if (i < 16) wfor(0, 4 + i);
      end
      enq(5'h06);
      repeat (8) @(posedge clk_sys);
      chk(cnt[0], 19);
      apb(1'b0, `MPD_A_CTRL, 32'h0);
      chk(rd & 32'h1, 32'h0);
      apb(1'b0, `MPD_A_PORTS, 32'h0);
      chk(rd & 32'h9F, 32'h07);
      apb(1'b1, `MPD_A_CMD, {28'h0, `MPD_CMD_TXACK});
      apb(1'b1, `MPD_A_CTRL, 32'h1);
      wfor(0, 20);
      fire(8'h01);
      apb(1'b1, `MPD_A_CMD, {28'h0, `MPD_CMD_TXACK});
      // Late collision, lost carrier, heartbeat error each clear enable
      for (i = 0; i < 3; i = i + 1) begin
         s = cnt[0];
         apb(1'b1, `MPD_A_CTRL, 32'h1 | ((32'h8 << i) & 32'h30));
         enq(5'h0A + i[4:0]);
         wfor(0, s + 1);
         fire(8'h04 << i);
         repeat (3) @(posedge clk_sys);
         apb(1'b0, `MPD_A_CTRL, 32'h0);
         chk(rd & 32'h1, 32'h0);
         apb(1'b1, `MPD_A_CMD, {28'h0, `MPD_CMD_TXACK});
      end
      // Receive with a slow allocator: good, bad, filtered, bad accepted
      slow <= 1'b1;
      apb(1'b1, `MPD_A_CTRL, 32'h2);
      rxf(2'h0, 1'b0, 1'b1);
      acc[0] = got_pn;
      rxf(2'h0, 1'b0, 1'b0);
      chk(rel_pn, got_pn);
      for (i = 0; i < 6; i = i + 1) begin
         apb(1'b1, `MPD_A_CTRL, {24'h0, FILT[i*12+4 +: 8]});
         rxf(FILT[i*12+2 +: 2], FILT[i*12+1], 1'b1);
         chk(cnt[1] - s, {31'h0, FILT[i*12]});
         if (FILT[i*12]) chk(rel_pn, got_pn);
         else begin
            j = j + 1;
            acc[j] = got_pn;
         end
      end
      apb(1'b1, `MPD_A_CTRL, 32'h6);
      rxf(2'h0, 1'b0, 1'b0);
      acc[5] = got_pn;
      for (i = 0; i < 6; i = i + 1) begin
         apb(1'b0, `MPD_A_PORTS, 32'h0);
         chk(rd & 32'h9F00, {19'h0, acc[i], 8'h00});
         apb(1'b1, `MPD_A_CMD, (i == 0) ? 32'h4 : 32'h3);
         repeat (3) @(posedge clk_sys);
         if (i == 0) chk(rel_pn, acc[0]);
      end
      apb(1'b0, `MPD_A_PORTS, 32'h0);
      chk(rd & 32'h8000, 32'h8000);
      // Refused allocation: overrun latched, enable kept, next frame flushed
      refuse <= 1'b1;
      fifo_ne <= 1'b1;
      fire(8'h20);
      repeat (8) @(posedge clk_sys);
      chk({31'h0, rx_overrun_irq}, 32'h1);
      apb(1'b0, `MPD_A_CTRL, 32'h0);
      chk(rd & 32'h2, 32'h2);
      refuse <= 1'b0;
      fire(8'h20);
      wfor(2, 1);
      fifo_ne <= 1'b0;
      repeat (8) @(posedge clk_sys);
      apb(1'b1, `MPD_A_STAT, 32'h4);
      repeat (3) @(posedge clk_sys);
      chk({31'h0, rx_overrun_irq}, 32'h0);
      end_sim;
   end
endmodule
